// file: rtl/mma_top.sv
// Purpose: Host-addressable management register bank on AHB-Lite
// Assumes: hclk 100 MHz, hresetn async low, async inputs synchronised
// Notes: Read answers after one wait state, writes after none
//
// Notes on behaviour
// - Lane-banked pages serve eight lanes per bank.
// - Bank k position i denotes absolute lane k*8+i, lanes 1 to 32.
// - Lane j sits at position ((j-1) mod 8)+1 in bank (j-1)/8.
// - Control registers leave reset at zero unless defined otherwise.
// - Masks of optional-page flags default to one.
// - Masks of vendor interrupt sources should also default to one.
// - Numeric multi-byte values place the most significant byte lowest.
// - Writes to read-only elements are accepted and change nothing.
// - Reads of write-only elements are accepted, value undefined.
// - Self-clearing field reads zero once the device acted on it.
// - Clear-on-read byte is cleared after being read.
// - Cleared flag sets again while its condition persists.
// - Host-and-device modified field used only under a handshake.
// - Any address readable and writable without bus error.
// - All required pages are implemented; others optional.
// - Advertisement tells which optional pages and banks exist.
// - Required fields exist whenever their page exists.
// - Advertised fields exist exactly when advertised.
// - Conditional fields operate only while their condition holds.
// - Typed multi-byte reporting register reads as atomic snapshot.
// - Accessible reserved locations read zero.
// - Interrupt asserted while any unmasked flag is set.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`include "mma_params.svh"

module mma_top
   import mma_pkg::*;
#(
   parameter int NUM_BANKS = 4,
   parameter bit HAS_COUNT = 1'b1
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Asynchronous device conditions
   input wire logic [7:0] evt_in,
   input wire logic [31:0] lane_stat_in,
   input wire logic act_done_in,
   // Device controls
   output logic [31:0] ctrl_o,
   output logic [31:0] lane_ctrl_o,
   output logic [7:0] cmd_pulse_o,
   output logic hs_start_o,
   output logic [31:0] key_o,
   output logic irq
);

   localparam int NLANE = 32;
   localparam int SW = 8 + NLANE + 1;

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers for outside signals
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   wire [7:0] evt_s = sync2_r[7:0];
   wire [NLANE-1:0] lstat_s = sync2_r[8 +: NLANE];
   wire act_done_s = sync2_r[SW-1];

   // Two stages, first stage read only by the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {act_done_in, lane_stat_in, evt_in};
         sync2_r <= sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB address phase capture
   logic [7:0] addr_r;
   logic wr_pend_r;
   logic rd_wait_r;
   logic rd_done_r;
   logic [31:0] hrdata_r;
   wire acc = hsel && hready && htrans[1];
   wire rd_acc = acc && !hwrite;
   wire wr_acc = acc && hwrite;

   // Reads stall one cycle so hrdata comes from a flop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r <= 8'h00;
         wr_pend_r <= 1'b0;
         rd_wait_r <= 1'b0;
         rd_done_r <= 1'b0;
      end else begin
         if (acc)
            addr_r <= haddr[7:0];
         wr_pend_r <= wr_acc;
         rd_wait_r <= rd_acc;
         rd_done_r <= rd_wait_r;
      end
   end

   assign hreadyout = !rd_wait_r;
   assign hresp = 1'b0; // Never an error, whatever the access
   assign hrdata = hrdata_r;

   // One stall cycle on every read, then the answer
   a_read_wait: assert property (@(posedge hclk)
      disable iff (!hresetn) rd_acc |=> !hreadyout ##1 hreadyout)
      else $error("read did not answer after one wait state");

   // Write strobes per register, none for read-only places
   wire wr_bank = wr_pend_r && addr_r == `MMA_OFF_BANK;
   wire wr_ctrl = wr_pend_r && addr_r == `MMA_OFF_CTRL;
   wire wr_cmd = wr_pend_r && addr_r == `MMA_OFF_CMD;
   wire wr_mask = wr_pend_r && addr_r == `MMA_OFF_MASK;
   wire wr_lctrl = wr_pend_r && addr_r == `MMA_OFF_LCTRL;
   wire wr_hshk = wr_pend_r && addr_r == `MMA_OFF_HSHK;
   wire wr_key = wr_pend_r && addr_r == `MMA_OFF_KEY;
   wire flag_rd_done = rd_done_r && addr_r == `MMA_OFF_FLAG;

   ////////////////////////////////////////////////////////////////////////
   // Plain control registers
   logic [1:0] bank_r;
   logic [31:0] ctrl_r;
   logic [7:0] mask_r;
   logic [31:0] key_r;

   // Zero defaults, optional and vendor masks set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_r <= `MMA_RST_BANK;
         ctrl_r <= `MMA_RST_CTRL;
         mask_r <= `MMA_RST_MASK;
         key_r <= 32'h0000_0000;
      end else begin
         if (wr_bank)
            bank_r <= hwdata[1:0]; // Host picks lane group
         if (wr_ctrl)
            ctrl_r <= hwdata;
         if (wr_mask)
            mask_r <= hwdata[7:0];
         if (wr_key)
            key_r <= hwdata;
      end
   end

   assign ctrl_o = ctrl_r;
   assign key_o = key_r;

   ////////////////////////////////////////////////////////////////////////
   // Self-clearing command byte: acted on the cycle after the write
   logic [7:0] cmd_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         cmd_r <= 8'h00;
      else if (wr_cmd)
         cmd_r <= hwdata[7:0];
      else
         cmd_r <= 8'h00; // Device has acted, field returns to zero
   end

   assign cmd_pulse_o = cmd_r;

   a_cmd_selfclr: assert property (@(posedge hclk)
      disable iff (!hresetn) wr_cmd && !wr_acc
      |=> cmd_r == $past(hwdata[7:0]) ##1 cmd_r == 8'h00)
      else $error("command byte did not self clear");

   ////////////////////////////////////////////////////////////////////////
   // Latched flags; a read clears only the bits that it returned, so an
   // event caught after the snapshot survives; set wins over clear
   logic [7:0] flag_r;
   wire [7:0] flag_ret = flag_rd_done ? hrdata_r[7:0] : 8'h00;
   wire [7:0] flag_nxt = (flag_r & ~flag_ret) | evt_s;

   // Clear only once hrdata has gone out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         flag_r <= 8'h00;
      else
         flag_r <= flag_nxt; // Persisting condition sets again
   end

   // Returned bits drop unless the condition is still present
   a_flag_clear: assert property (@(posedge hclk)
      disable iff (!hresetn) flag_rd_done
      |=> (flag_r & $past(hrdata_r[7:0] & ~evt_s)) == 8'h00)
      else $error("flag byte not cleared after read");

   a_flag_hold: assert property (@(posedge hclk)
      disable iff (!hresetn)
      1'b1 |=> (flag_r & $past(evt_s)) == $past(evt_s))
      else $error("present condition not latched");

   // Registered request, level while any unmasked flag stands
   logic irq_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         irq_r <= 1'b0;
      else
         irq_r <= |(flag_r & ~mask_r);
   end

   assign irq = irq_r;

   // Interrupt follows unmasked flags one cycle later, both ways
   a_irq_level: assert property (@(posedge hclk)
      disable iff (!hresetn) |(flag_r & ~mask_r) |=> irq)
      else $error("interrupt not asserted for unmasked flag");

   a_irq_quiet: assert property (@(posedge hclk)
      disable iff (!hresetn) !(|(flag_r & ~mask_r)) |=> !irq)
      else $error("interrupt asserted with no unmasked flag");

   ////////////////////////////////////////////////////////////////////////
   // Lane-banked control and status, one generate per absolute lane
   logic [NLANE-1:0] lane_ctrl_r;
   wire bank_ok = int'(bank_r) < NUM_BANKS; // Absent banks read zero

   genvar j;
   generate
      for (j = 0; j < NLANE; j++) begin : g_lane
         // Lane j+1 at bank j/8, position (j mod 8)+1
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn)
               lane_ctrl_r[j] <= 1'b0;
            else if (wr_lctrl && bank_ok &&
                     int'(bank_r) == j / `MMA_LANES_BANK)
               lane_ctrl_r[j] <= hwdata[j % `MMA_LANES_BANK];
         end
      end
   endgenerate

   assign lane_ctrl_o = lane_ctrl_r;

   // Banked write lands in the selected group; other groups are not checked
   a_bank_write: assert property (@(posedge hclk)
      disable iff (!hresetn) wr_lctrl && int'(bank_r) < NUM_BANKS
      |=> lane_ctrl_r[$past(bank_r)*8 +: 8] == $past(hwdata[7:0]))
      else $error("banked lane write missed its lane group");

   // Writes to read-only places leave ctrl_r, mask_r and lane_ctrl_r alone
   a_ro_write: assert property (@(posedge hclk)
      disable iff (!hresetn)
      wr_pend_r && (addr_r == `MMA_OFF_ADV || addr_r == `MMA_OFF_LSTAT)
      |=> $stable(ctrl_r) && $stable(mask_r) && $stable(lane_ctrl_r))
      else $error("read-only write changed state");

   // Status is meaningful only for enabled lanes
   wire [NLANE-1:0] lstat_live = lstat_s & lane_ctrl_r;
   wire [7:0] lctrl_win = bank_ok ? lane_ctrl_r[bank_r*8 +: 8] : 8'h00;
   wire [7:0] lstat_win = bank_ok ? lstat_live[bank_r*8 +: 8] : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Event counter, typed 32-bit reporting value
   logic [31:0] cnt_r;
   logic evt0_d_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= 32'h0000_0000;
         evt0_d_r <= 1'b0;
      end else begin
         evt0_d_r <= evt_s[0];
         if (HAS_COUNT && evt_s[0] && !evt0_d_r)
            cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   // Most significant byte in the lowest byte lane
   wire [31:0] cnt_be = {cnt_r[7:0], cnt_r[15:8], cnt_r[23:16], cnt_r[31:24]};

   a_count_be: assert property (@(posedge hclk)
      disable iff (!hresetn)
      rd_wait_r && addr_r == `MMA_OFF_COUNT && HAS_COUNT
      |=> hrdata[7:0] == $past(cnt_r[31:24]))
      else $error("counter not most significant byte first");

   ////////////////////////////////////////////////////////////////////////
   // Shared request field: host raises request, device answers done
   mma_hs_e hs_st_r;
   logic hs_req_r;
   logic hs_done_r;
   wire hs_finish = hs_st_r == MMA_HS_BUSY && act_done_s;

   // Both parties touch it only through this exchange
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hs_st_r <= MMA_HS_IDLE;
         hs_req_r <= 1'b0;
         hs_done_r <= 1'b0;
      end else begin
         case (hs_st_r)
            MMA_HS_IDLE: begin
               if (hs_req_r)
                  hs_st_r <= MMA_HS_BUSY;
            end
            MMA_HS_BUSY: begin
               if (act_done_s)
                  hs_st_r <= MMA_HS_IDLE;
            end
            default: hs_st_r <= MMA_HS_IDLE;
         endcase
         // Device update wins over a host write in the same cycle
         if (hs_finish) begin
            hs_req_r <= 1'b0;
            hs_done_r <= 1'b1;
         end else if (wr_hshk) begin
            hs_req_r <= hwdata[`MMA_HS_REQ];
            hs_done_r <= hwdata[`MMA_HS_DONE];
         end
      end
   end

   assign hs_start_o = hs_st_r == MMA_HS_IDLE && hs_req_r;

   a_hs_done: assert property (@(posedge hclk)
      disable iff (!hresetn)
      hs_finish |=> hs_done_r && !hs_req_r && hs_st_r == MMA_HS_IDLE)
      else $error("handshake completion not reflected");

   ////////////////////////////////////////////////////////////////////////
   // Read data selection
   wire [31:0] adv_val = {24'h000000, 4'(NUM_BANKS), 3'h0, HAS_COUNT};
   wire [31:0] rd_mux =
      addr_r == `MMA_OFF_ADV   ? adv_val : // Advertises options
      addr_r == `MMA_OFF_BANK  ? {30'h0, bank_r} :
      addr_r == `MMA_OFF_CTRL  ? ctrl_r : // Required, always present
      addr_r == `MMA_OFF_CMD   ? {24'h0, cmd_r} :
      addr_r == `MMA_OFF_FLAG  ? {24'h0, flag_r} :
      addr_r == `MMA_OFF_MASK  ? {24'h0, mask_r} :
      addr_r == `MMA_OFF_LCTRL ? {24'h0, lctrl_win} :
      addr_r == `MMA_OFF_LSTAT ? {24'h0, lstat_win} :
      addr_r == `MMA_OFF_COUNT ? (HAS_COUNT ? cnt_be : 32'h0) :
      addr_r == `MMA_OFF_HSHK  ? {30'h0, hs_done_r, hs_req_r} :
      32'h0000_0000; // Write-only key and reserved read zero

   // Whole word sampled in one edge, never torn
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata_r <= 32'h0000_0000;
      else if (rd_wait_r)
         hrdata_r <= rd_mux;
   end

endmodule

// file: rtl/mma_params.svh
// Purpose: Offsets, reset values and field positions of the management bank
// Assumes: One aligned 32-bit word per register on AHB-Lite
// Notes: Definitions only
`ifndef MMA_PARAMS_SVH
`define MMA_PARAMS_SVH

// Register byte offsets
`define MMA_OFF_ADV    8'h00
`define MMA_OFF_BANK   8'h04
`define MMA_OFF_CTRL   8'h08
`define MMA_OFF_CMD    8'h0C
`define MMA_OFF_FLAG   8'h10
`define MMA_OFF_MASK   8'h14
`define MMA_OFF_LCTRL  8'h18
`define MMA_OFF_LSTAT  8'h1C
`define MMA_OFF_COUNT  8'h20
`define MMA_OFF_HSHK   8'h24
`define MMA_OFF_KEY    8'h28

// Reset values
`define MMA_RST_CTRL   32'h0000_0000
`define MMA_RST_MASK   8'hF0
`define MMA_RST_BANK   2'h0

// Field positions
`define MMA_HS_REQ     0
`define MMA_HS_DONE    1
`define MMA_ADV_CNT    0
`define MMA_ADV_BANKS  4

// Lanes per bank
`define MMA_LANES_BANK 8

`endif

// file: rtl/mma_pkg.sv
// Purpose: Types shared by the management bank
// Assumes: Constants live in mma_params.svh
// Notes: Types only
package mma_pkg;
   typedef enum logic {
      MMA_HS_IDLE,
      MMA_HS_BUSY
   } mma_hs_e;
   typedef logic [7:0] mma_byte_t;
endpackage

// file: verif/mma_host_model.sv
// Purpose: AHB-Lite host master for the management bank
// Assumes: One slave, hready taken from its hreadyout
// Notes: Tasks are called from the bench top
`timescale 1ns/10ps
module mma_host_model (
   // Clock and slave answer
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Request signals
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   ///////////////////////////////////////////////////////////////////////
   // Idle bus at time zero, word size only
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // Address phase held until hready; stale write data inverted
   task automatic req(input logic [31:0] a, input logic w);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hwdata <= ~hwdata;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
   endtask

   // Single word write, returns at the edge ending the data phase
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      req(a, 1'b1);
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask

   // Whole-word reads only, no atomicity assumed across words
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      req(a, 1'b0);
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask
endmodule

// file: verif/mma_top_tb_top.sv
// Purpose: Self-checking bench of the management bank
// Assumes: Host model drives AHB, bench drives device conditions
// Notes: Fixed waits cover the two-stage input synchronisers
`timescale 1ns/10ps
`include "mma_params.svh"
module mma_top_tb_top;
   import mma_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic act_done_in, hs_start_o, irq;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, lane_stat_in, ctrl_o;
   logic [31:0] lane_ctrl_o, key_o, v;
   logic [7:0] evt_in, cmd_pulse_o;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;

   ///////////////////////////////////////////////////////////////////////
   // Clock, reset and a hang limit
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   initial begin
      hresetn = 1'b0;
      evt_in = 8'h00;
      lane_stat_in = 32'h0000_0000;
      act_done_in = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end

   mma_host_model u_host (.hclk(hclk), .hready(hreadyout),
      .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   mma_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .evt_in(evt_in),
      .lane_stat_in(lane_stat_in), .act_done_in(act_done_in),
      .ctrl_o(ctrl_o), .lane_ctrl_o(lane_ctrl_o),
      .cmd_pulse_o(cmd_pulse_o), .hs_start_o(hs_start_o),
      .key_o(key_o), .irq(irq));

   ///////////////////////////////////////////////////////////////////////
   // Compare and close
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic rchk(input string nm, input logic [31:0] a, e);
      u_host.rd(a, v);
      chk(nm, v, e);
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   task automatic complete_run();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   ///////////////////////////////////////////////////////////////////////
   // Reset values, read-only, reserved and write-only places
   task automatic t_reset_access();
      rchk("ctrl", `MMA_OFF_CTRL, 32'h0);
      rchk("mask", `MMA_OFF_MASK, 32'hF0);
      rchk("bank", `MMA_OFF_BANK, 32'h0);
      rchk("adv", `MMA_OFF_ADV, 32'h41);
      u_host.wr(`MMA_OFF_ADV, 32'hFFFF_FFFF);
      rchk("adv ro", `MMA_OFF_ADV, 32'h41);
      u_host.wr(32'h2C, 32'hFFFF_FFFF);
      rchk("reserved", 32'h2C, 32'h0);
      u_host.wr(`MMA_OFF_CTRL, 32'h1234_ABCD);
      #1 chk("ctrl_o", ctrl_o, 32'h1234_ABCD);
      u_host.wr(`MMA_OFF_KEY, 32'hC3C3_5A5A);
      #1 chk("key_o", key_o, 32'hC3C3_5A5A);
      rchk("key rd", `MMA_OFF_KEY, 32'h0);
   endtask

   // Self-clearing command byte pulses once and reads zero
   task automatic t_cmd();
      u_host.wr(`MMA_OFF_CMD, 32'h5A);
      #1 chk("cmd pulse", {24'h0, cmd_pulse_o}, 32'h5A);
      @(posedge hclk);
      #1 chk("cmd clr", {24'h0, cmd_pulse_o}, 32'h0);
      rchk("cmd rd", `MMA_OFF_CMD, 32'h0);
   endtask

   // Edges on a 160 ns link-rate line, count read MSB first
   task automatic t_count();
      repeat (5) begin
         evt_in[0] <= 1'b1;
         #80 evt_in[0] <= 1'b0;
         #80;
      end
      repeat (4) @(posedge hclk);
      rchk("count", `MMA_OFF_COUNT, 32'h0500_0000);
      rchk("flag ev", `MMA_OFF_FLAG, 32'h01);
   endtask

   // Latched flags, clear after read, re-set and masking
   task automatic t_flags();
      rchk("flag0", `MMA_OFF_FLAG, 32'h0);
      @(posedge hclk) evt_in <= 8'h81;
      @(posedge hclk) evt_in <= 8'h00;
      repeat (6) @(posedge hclk);
      #1 chk("irq on", {31'h0, irq}, 32'h1);
      rchk("flag latched", `MMA_OFF_FLAG, 32'h81);
      rchk("flag cleared", `MMA_OFF_FLAG, 32'h0);
      #1 chk("irq off", {31'h0, irq}, 32'h0);
      @(posedge hclk) evt_in <= 8'h02;
      repeat (6) @(posedge hclk);
      rchk("cond 1", `MMA_OFF_FLAG, 32'h02);
      rchk("cond 2", `MMA_OFF_FLAG, 32'h02);
      u_host.wr(`MMA_OFF_MASK, 32'hFF);
      repeat (3) @(posedge hclk);
      #1 chk("irq masked", {31'h0, irq}, 32'h0);
      @(posedge hclk) evt_in <= 8'h00;
   endtask

   // Lane groups of eight selected by bank index
   task automatic t_lanes();
      logic [7:0] lv [4];
      lv = '{8'h19, 8'h2A, 8'h3C, 8'h4D};
      for (int k = 0; k < 4; k++) begin
         u_host.wr(`MMA_OFF_BANK, k);
         u_host.wr(`MMA_OFF_LCTRL, {24'h0, lv[k]});
      end
      #1 chk("lane ctrl", lane_ctrl_o, 32'h4D3C_2A19);
      @(posedge hclk) lane_stat_in <= 32'h0008_0000;
      repeat (4) @(posedge hclk);
      for (int k = 0; k < 4; k++) begin
         u_host.wr(`MMA_OFF_BANK, k);
         rchk("lane 20", `MMA_OFF_LSTAT, (k == 2) ? 32'h8 : 32'h0);
      end
   endtask

   // Request and done bits under the handshake
   task automatic t_hshk();
      logic seen;
      seen = 1'b0;
      u_host.wr(`MMA_OFF_HSHK, 32'h1);
      repeat (3) begin
         #1 if (hs_start_o === 1'b1) seen = 1'b1;
         @(posedge hclk);
      end
      chk("hs start", {31'h0, seen}, 32'h1);
      rchk("hs pend", `MMA_OFF_HSHK, 32'h1);
      act_done_in <= 1'b1;
      repeat (5) @(posedge hclk);
      rchk("hs done", `MMA_OFF_HSHK, 32'h2);
      act_done_in <= 1'b0;
   endtask

   ///////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      wait (hresetn === 1'b1);
      t_reset_access();
      t_cmd();
      t_count();
      t_flags();
      t_lanes();
      t_hshk();
      complete_run();
   end
endmodule
